// *** logic/ssp_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; read data is read straight from the array, not from an output register.
 */
`timescale 1ns/1ps
module ssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_r[rp_r];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data_i;
				wp_r <= wp_r + 1'b1;
			end
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ssp_fifo

// *** logic/ssp_pkg.sv ***
/*
 * Constants and carrier types for the serial slave port.
 * Assumes one 50 MHz system clock and a synchronous active-high reset.
 */
// Overview of operation
// R1: Enabled non-master port acts as slave
// R2: Eight counted edges set flag, fill buffer
// R3: Data port read returns receive buffer
// R4: Slave never starts a transfer itself
// R5: Written bytes pass through transmit buffer
// R6: Empty shifter loads transmit buffer immediately
// R7: Busy shifter loads after final edge
// R8: Mode bits 0,1 select four-wire default
// R9: Four-wire mode uses select pin input
// R10: Select low enables, high disables slave
// R11: Select falling edge clears bit counter
// R12: Master lowers select two clocks early
// R13: Mode bits 0,0 ignore select pin
// R14: Three-wire bus holds only this slave
// R15: Three-wire counter cleared by enable toggle
// R16: Clock and select synchronised before edges
package ssp_pkg;

	localparam int SSP_BITS = 8;
	localparam int SSP_FIFO_DEPTH = 16;
	localparam int SSP_CLK_HZ = 50_000_000;
	localparam int SSP_SETUP_CLKS = 2;
	localparam logic [1:0] SSP_MODE_4W = 2'h1;
	localparam logic [1:0] SSP_MODE_3W = 2'h0;
	localparam logic [7:0] SSP_BYTE_RST = 8'h00;
	localparam logic [3:0] SSP_CNT_RST = 4'h0;
	localparam int SSP_SYNC_STAGES = 2;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic sel_n;
	} ssp_pins_t;

	typedef struct packed {
		logic [SSP_SYNC_STAGES-1:0] sck_s;
		logic [SSP_SYNC_STAGES-1:0] mosi_s;
		logic [SSP_SYNC_STAGES-1:0] sel_s;
		logic sck_d;
		logic sel_d;
		logic en_d;
		logic [3:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic sh_full;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] rx_buf;
		logic done;
		logic miso;
	} ssp_state_t;

endpackage : ssp_pkg

// *** logic/ssp_slave.sv ***
/*
 * Slave side of a synchronous serial port, mode 0 timing (sample on rising,
 * shift on falling). Assumes the external master owns the serial clock.
 */
`timescale 1ns/1ps
module ssp_slave
	import ssp_pkg::*;
#(
	parameter int DEPTH = SSP_FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic port_enable_bit_i,
	input wire logic master_mode_i,
	input wire logic select_mode_high_bit_i,
	input wire logic select_mode_low_bit_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic slave_select_n_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [7:0] shift_data_port_o,
	output logic transfer_done_flag_o,
	input wire logic done_clr_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i
);
	ssp_state_t st_r;
	ssp_state_t st_nxt;
	ssp_pins_t pin;
	logic slave_on;
	logic four_w;
	logic sel_act;
	logic sck_rise;
	logic sck_fall;
	logic sel_fall;
	logic byte_end;
	logic fifo_ready;
	logic [7:0] fifo_data;
	logic fifo_pop;

	// Head of the FIFO moves on whenever the transmit buffer frees up
	assign fifo_pop = fifo_ready && (!st_r.tx_full || (!st_r.sh_full || byte_end));
	assign four_w = !select_mode_high_bit_i && (select_mode_low_bit_i == SSP_MODE_4W[0]);
	assign slave_on = port_enable_bit_i && !master_mode_i; // [R1]
	assign pin.sck = st_r.sck_s[SSP_SYNC_STAGES-1];
	assign pin.mosi = st_r.mosi_s[SSP_SYNC_STAGES-1];
	assign pin.sel_n = st_r.sel_s[SSP_SYNC_STAGES-1];
	// Select counts only in four-wire mode; three-wire ignores the pin
	assign sel_act = four_w ? !pin.sel_n : 1'b1; // [R8] [R9] [R10] [R13]
	assign sck_rise = pin.sck && !st_r.sck_d; // [R16]
	assign sck_fall = !pin.sck && st_r.sck_d;
	assign sel_fall = four_w && !pin.sel_n && st_r.sel_d; // [R11]
	assign byte_end = slave_on && sel_act && sck_rise &&
		st_r.bit_cnt == 4'(SSP_BITS - 1);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.sck_s = {st_r.sck_s[0], sck_i}; // [R16]
		st_nxt.mosi_s = {st_r.mosi_s[0], mosi_i};
		st_nxt.sel_s = {st_r.sel_s[0], slave_select_n_i};
		st_nxt.sck_d = pin.sck;
		st_nxt.sel_d = pin.sel_n;
		st_nxt.en_d = port_enable_bit_i;
		if (!slave_on) begin
			// Disable clears count; re-enable starts fresh
			st_nxt.bit_cnt = SSP_CNT_RST; // [R15]
		end else if (sel_fall) begin
			st_nxt.bit_cnt = SSP_CNT_RST; // [R11]
		end else if (sel_act && sck_rise) begin
			// Only the master's clock advances a transfer
			st_nxt.shift_in = {st_r.shift_in[6:0], pin.mosi}; // [R4]
			st_nxt.bit_cnt = byte_end ? SSP_CNT_RST : st_r.bit_cnt + 4'h1; // [R2]
		end else if (sel_act && sck_fall && st_r.bit_cnt != SSP_CNT_RST) begin
			st_nxt.shift_out = {st_r.shift_out[6:0], 1'b0};
		end
		if (byte_end) begin
			st_nxt.rx_buf = {st_r.shift_in[6:0], pin.mosi}; // [R2]
			st_nxt.done = 1'b1;
			st_nxt.sh_full = 1'b0;
		end else if (done_clr_i) begin
			st_nxt.done = 1'b0;
		end
		// Transmit buffer fills from the FIFO head
		if (!st_r.tx_full && fifo_ready)
			st_nxt.tx_full = 1'b1; // [R5]
		if (st_r.tx_full && (!st_r.sh_full || byte_end)) begin
			// Empty shifter loads at once, busy one after last edge
			st_nxt.shift_out = st_r.tx_buf; // [R6] [R7]
			st_nxt.sh_full = 1'b1;
			st_nxt.tx_full = !st_r.tx_full ? 1'b0 : fifo_ready;
		end
		if (fifo_pop)
			st_nxt.tx_buf = fifo_data; // [R5]
		st_nxt.miso = st_nxt.shift_out[7];
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.sck_s <= '0;
			st_r.sel_s <= '1;
			st_r.sel_d <= 1'b1;
			st_r.rx_buf <= SSP_BYTE_RST;
			st_r.shift_out <= SSP_BYTE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	ssp_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_data_i(wr_data_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_ready),
		.out_ready_i(fifo_pop)
	);

	assign shift_data_port_o = st_r.rx_buf; // [R3]
	assign transfer_done_flag_o = st_r.done;
	assign rx_data_o = st_r.rx_buf;
	assign rx_valid_o = st_r.done;
	assign miso_o = st_r.miso;
	assign miso_oe_n_o = !(slave_on && sel_act); // [R9]

	////////////////////////////////////////////////////////////////////////
	property p_done_on_byte;
		@(posedge ref_clk_i) disable iff (rst_i) byte_end |=> transfer_done_flag_o;
	endproperty
	a_done_on_byte: assert property (p_done_on_byte) else $error("flag not set"); // [R2]
	property p_rx_from_shift;
		@(posedge ref_clk_i) disable iff (rst_i)
		byte_end |=> rx_data_o == $past({st_r.shift_in[6:0], pin.mosi});
	endproperty
	a_rx_from_shift: assert property (p_rx_from_shift) else $error("rx buffer wrong"); // [R2]
	property p_read_buf;
		@(posedge ref_clk_i) disable iff (rst_i) shift_data_port_o == st_r.rx_buf;
	endproperty
	a_read_buf: assert property (p_read_buf) else $error("read not buffer"); // [R3]
	property p_no_self_start;
		@(posedge ref_clk_i) disable iff (rst_i)
		!sck_rise && !sel_fall && slave_on |=> st_r.bit_cnt == $past(st_r.bit_cnt);
	endproperty
	a_no_self_start: assert property (p_no_self_start) else $error("self start"); // [R4]
	property p_sel_clear;
		@(posedge ref_clk_i) disable iff (rst_i) sel_fall |=> st_r.bit_cnt == SSP_CNT_RST;
	endproperty
	a_sel_clear: assert property (p_sel_clear) else $error("count not cleared"); // [R11]
	property p_dis_clear;
		@(posedge ref_clk_i) disable iff (rst_i) !slave_on |=> st_r.bit_cnt == SSP_CNT_RST;
	endproperty
	a_dis_clear: assert property (p_dis_clear) else $error("disable no clear"); // [R15]
	property p_idle_4w;
		@(posedge ref_clk_i) disable iff (rst_i)
		four_w && pin.sel_n && slave_on |=> $stable(st_r.bit_cnt);
	endproperty
	a_idle_4w: assert property (p_idle_4w) else $error("active while deselected"); // [R10]
	property p_load_empty;
		@(posedge ref_clk_i) disable iff (rst_i)
		st_r.tx_full && !st_r.sh_full |=> st_r.sh_full;
	endproperty
	a_load_empty: assert property (p_load_empty) else $error("no immediate load"); // [R6]
	c_byte: cover property (@(posedge ref_clk_i) byte_end);
	c_sel: cover property (@(posedge ref_clk_i) sel_fall);
	c_reload: cover property (@(posedge ref_clk_i) byte_end && st_r.tx_full);
	c_three_wire: cover property (@(posedge ref_clk_i) !four_w && byte_end);
	c_fill: cover property (@(posedge ref_clk_i) !wr_ready_o);

	////////////////////////////////////////////////////////////////////////
	// Pin handling and output enable
	property p_master_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		!slave_on
		|-> miso_oe_n_o;
	endproperty
	a_master_off: assert property (p_master_off) else $error("drives while off"); // [R1]
	property p_drive_on;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on && sel_act
		|-> !miso_oe_n_o;
	endproperty
	a_drive_on: assert property (p_drive_on) else $error("miso not driven"); // [R9]
	property p_miso_msb;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on
		|-> miso_o == st_r.shift_out[7];
	endproperty
	a_miso_msb: assert property (p_miso_msb) else $error("miso not msb"); // [R1]
	property p_sync_sck;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on
		|-> pin.sck == $past(sck_i, 2);
	endproperty
	a_sync_sck: assert property (p_sync_sck) else $error("sck not two stages"); // [R16]
	property p_sync_sel;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on
		|-> pin.sel_n == $past(slave_select_n_i, 2);
	endproperty
	a_sync_sel: assert property (p_sync_sel) else $error("select not two stages"); // [R16]
	property p_mode_4w;
		@(posedge ref_clk_i) disable iff (rst_i)
		!select_mode_high_bit_i && select_mode_low_bit_i
		|-> four_w;
	endproperty
	a_mode_4w: assert property (p_mode_4w) else $error("four-wire not chosen"); // [R8]
	property p_3w_no_sel;
		@(posedge ref_clk_i) disable iff (rst_i)
		!four_w
		|-> !sel_fall;
	endproperty
	a_3w_no_sel: assert property (p_3w_no_sel) else $error("select used in 3-wire"); // [R13]

	////////////////////////////////////////////////////////////////////////
	// Bit counting and receive side
	property p_count_step;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on && sel_act && sck_rise && !sel_fall && !byte_end
		|=> st_r.bit_cnt == $past(st_r.bit_cnt) + 4'h1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count not stepped"); // [R2]
	property p_3w_step;
		@(posedge ref_clk_i) disable iff (rst_i)
		!four_w && slave_on && sck_rise && !byte_end
		|=> st_r.bit_cnt == $past(st_r.bit_cnt) + 4'h1;
	endproperty
	a_3w_step: assert property (p_3w_step) else $error("3-wire count stuck"); // [R13]
	property p_count_range;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on
		|-> st_r.bit_cnt < 4'(SSP_BITS);
	endproperty
	a_count_range: assert property (p_count_range) else $error("count out of range"); // [R2]
	property p_byte_wrap;
		@(posedge ref_clk_i) disable iff (rst_i)
		byte_end
		|=> st_r.bit_cnt == SSP_CNT_RST;
	endproperty
	a_byte_wrap: assert property (p_byte_wrap) else $error("count not wrapped"); // [R2]
	property p_done_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		transfer_done_flag_o && !done_clr_i
		|=> transfer_done_flag_o;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("flag dropped"); // [R2]
	property p_done_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		done_clr_i && !byte_end
		|=> !transfer_done_flag_o;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("flag not cleared"); // [R2]
	property p_done_quiet;
		@(posedge ref_clk_i) disable iff (rst_i)
		!transfer_done_flag_o && !byte_end
		|=> !transfer_done_flag_o;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("flag set unprompted"); // [R4]
	property p_rx_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		!byte_end
		|=> $stable(rx_data_o);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx buffer moved"); // [R3]
	property p_rx_port;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on
		|-> shift_data_port_o == rx_data_o;
	endproperty
	a_rx_port: assert property (p_rx_port) else $error("port not rx buffer"); // [R3]

	////////////////////////////////////////////////////////////////////////
	// Transmit buffering
	property p_reload_busy;
		@(posedge ref_clk_i) disable iff (rst_i)
		byte_end && st_r.tx_full
		|=> st_r.sh_full && st_r.shift_out == $past(st_r.tx_buf);
	endproperty
	a_reload_busy: assert property (p_reload_busy) else $error("no reload at end"); // [R7]
	property p_busy_wait;
		@(posedge ref_clk_i) disable iff (rst_i)
		st_r.sh_full && st_r.tx_full && !byte_end
		|=> st_r.tx_full && $stable(st_r.tx_buf);
	endproperty
	a_busy_wait: assert property (p_busy_wait) else $error("early reload"); // [R7]
	property p_tx_pop;
		@(posedge ref_clk_i) disable iff (rst_i)
		fifo_pop
		|=> st_r.tx_full;
	endproperty
	a_tx_pop: assert property (p_tx_pop) else $error("tx buffer not filled"); // [R5]
	property p_tx_data;
		@(posedge ref_clk_i) disable iff (rst_i)
		fifo_pop
		|=> st_r.tx_buf == $past(fifo_data);
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("tx buffer data wrong"); // [R5]
	property p_shift_fall;
		@(posedge ref_clk_i) disable iff (rst_i)
		slave_on && sel_act && sck_fall && !sel_fall && st_r.bit_cnt != SSP_CNT_RST &&
			!(st_r.tx_full && !st_r.sh_full)
		|=> st_r.shift_out == {$past(st_r.shift_out[6:0]), 1'b0};
	endproperty
	a_shift_fall: assert property (p_shift_fall) else $error("no shift on fall"); // [R1]
endmodule : ssp_slave

// *** verif/ssp_master_model.sv ***
/* Master model: owns sck and select, mode 0, MSB first.
   Assumes the slave shifts on sck fall, so miso is read at the rise. */
`timescale 1ns/1ps
module ssp_master_model
	import ssp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic mosi_o,
	output logic sel_n_o
);
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b1;
		sel_n_o = 1'b1;
	end
	// Sck stands still between frames; half sets the speed
	task automatic frame(input logic [7:0] tx, input int n, input int half, input logic sel,
			output logic [7:0] rx);
		rx = 8'h00;
		@(negedge ref_clk_i);
		sel_n_o = ~sel;
		repeat (SSP_SETUP_CLKS + 1) @(negedge ref_clk_i);
		for (int i = 0; i < n; i++) begin
			mosi_o = tx[7-i];
			repeat (half) @(negedge ref_clk_i);
			sck_o = 1'b1;
			rx = {rx[6:0], miso_i};
			repeat (half) @(negedge ref_clk_i);
			sck_o = 1'b0;
		end
		repeat (half) @(negedge ref_clk_i);
		sel_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask : frame
endmodule : ssp_master_model

// *** verif/ssp_slave_bench.sv ***
/* Self-checking bench for the serial slave port.
   Assumes the master model is the only party on the link. */
`timescale 1ns/1ps
module ssp_slave_bench;
	import ssp_pkg::*;
	logic ref_clk, rst, en, mm, mh, ml, sck, mosi, sel_n, miso, miso_oe_n, miso_w, clr;
	logic wr_valid, wr_ready, flag, rx_valid;
	logic [7:0] wr_data, sdp, rx_data, mrx;
	int fail_count = 0;
	int total_checks = 0;
	int n = 0;
	// Pull-up while the slave releases miso
	assign miso_w = miso_oe_n ? 1'b1 : miso;
	ssp_slave dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .port_enable_bit_i(en),
		.master_mode_i(mm), .select_mode_high_bit_i(mh), .select_mode_low_bit_i(ml),
		.sck_i(sck), .mosi_i(mosi), .slave_select_n_i(sel_n), .miso_o(miso),
		.miso_oe_n_o(miso_oe_n), .wr_data_i(wr_data), .wr_valid_i(wr_valid),
		.wr_ready_o(wr_ready), .shift_data_port_o(sdp), .transfer_done_flag_o(flag),
		.done_clr_i(clr), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(1'b1));
	// Sole slave on the bus, also in three-wire mode
	ssp_master_model master_u (.ref_clk_i(ref_clk), .miso_i(miso_w), .sck_o(sck),
		.mosi_o(mosi), .sel_n_o(sel_n));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic put(input logic [7:0] d);
		int k;
		@(negedge ref_clk);
		wr_data = d;
		wr_valid = 1'b1;
		for (k = 0; k < 50 && wr_ready !== 1'b1; k++) @(negedge ref_clk);
		if (k == 50) begin
			fail_count++;
			end_of_test;
		end
		@(negedge ref_clk);
		wr_valid = 1'b0;
	endtask : put
	task automatic xfer(input logic [7:0] tx, input int half, input logic s, ckm,
			input logic [7:0] em, es);
		logic [7:0] r;
		master_u.frame(tx, 8, half, s, r);
		repeat (4) @(negedge ref_clk);
		if (ckm) check(r, em);
		check({7'h00, flag}, 8'h01);
		check({7'h00, rx_valid}, 8'h01);
		check(sdp, es);
		check(rx_data, es);
		clr = 1'b1;
		@(negedge ref_clk);
		clr = 1'b0;
		@(negedge ref_clk);
		check({7'h00, flag}, 8'h00);
	endtask : xfer
	task automatic quiet(input int bits, input logic s);
		master_u.frame(8'hff, bits, 4, s, mrx);
		repeat (4) @(negedge ref_clk);
		check({7'h00, flag}, 8'h00);
	endtask : quiet
	initial begin
		rst = 1'b1;
		{en, mm, mh, ml, wr_valid, clr, wr_data} = {4'h9, 2'h0, 8'h00};
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		check(sdp, 8'h00);
		check({7'h00, flag}, 8'h00);
		put(8'ha5);
		put(8'h5a);
		repeat (20) @(negedge ref_clk);
		check({7'h00, flag}, 8'h00);
		xfer(8'h3c, 4, 1'b1, 1'b1, 8'ha5, 8'h3c);
		xfer(8'hc3, 6, 1'b1, 1'b1, 8'h5a, 8'hc3);
		quiet(8, 1'b0);
		check({7'h00, miso_oe_n}, 8'h01);
		mm = 1'b1;
		quiet(8, 1'b1);
		check({7'h00, miso_oe_n}, 8'h01);
		mm = 1'b0;
		quiet(3, 1'b1);
		put(8'h96);
		xfer(8'h81, 4, 1'b1, 1'b1, 8'h96, 8'h81);
		ml = 1'b0;
		xfer(8'h7e, 4, 1'b0, 1'b0, 8'h00, 8'h7e);
		quiet(5, 1'b0);
		check({7'h00, miso_oe_n}, 8'h00);
		en = 1'b0;
		repeat (2) @(negedge ref_clk);
		en = 1'b1;
		xfer(8'he7, 4, 1'b0, 1'b0, 8'h00, 8'he7);
		@(negedge ref_clk);
		wr_valid = 1'b1;
		while (wr_ready === 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		wr_valid = 1'b0;
		check({7'h00, wr_ready}, 8'h00);
		check((n >= SSP_FIFO_DEPTH) ? 8'h01 : 8'h00, 8'h01);
		xfer(8'h44, 6, 1'b0, 1'b1, 8'h96, 8'h44);
		end_of_test;
	end
endmodule : ssp_slave_bench
